// >>> cbi_boot_ctrl.sv
// boot integrity checker, flash ecc path, watchdog and jtag pin gating
`timescale 1ns/1ps

module cbi_boot_ctrl #(
  parameter int FW_BASE    = 16'h0000,
  parameter int FW_LEN     = 16,
  parameter int CFG_BASE   = 16'h0100,
  parameter int CFG_LEN    = 16,
  parameter int LOG_BASE   = 16'h0200,
  parameter int LOG_LEN    = 8,
  parameter int WDT_CYCLES = cbi_pkg::WDT_CYCLES,
  parameter int FPW_N      = 8
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  // address detect and firmware handshakes
  input  wire logic [6:0]           bus_addr_in,
  input  wire logic                 wdt_kick_in,
  input  wire logic                 alert_clr_in,
  output logic                      wdt_rst_out,
  output logic                      bus_alert_out,
  output logic                      fw_run_out,
  output logic                      use_default_cfg_out,
  output cbi_pkg::cbi_status_t      status_out,
  // data flash
  output cbi_pkg::cbi_rd_req_t      fl_rd_out,
  input  wire logic [37:0]          fl_rd_data_in,
  input  wire logic                 fl_rd_valid_in,
  output cbi_pkg::cbi_fl_wr_t       fl_wr_out,
  // host side flash access and parameters
  input  wire logic                 wp_disable_in,
  input  wire logic                 host_erase_in,
  input  wire cbi_pkg::cbi_host_wr_t host_wr_in,
  input  wire cbi_pkg::cbi_rd_req_t host_rd_in,
  output logic [31:0]               host_rd_data_out,
  output logic                      host_rd_valid_out,
  input  wire cbi_pkg::cbi_param_t  param_in,
  output logic                      param_ok_out,
  output logic                      param_err_out,
  // shared jtag/gpio pins: 0 tck, 1 tms, 2 tdi, 3 tdo
  input  wire logic [3:0]           gpio_o_in,
  input  wire logic [3:0]           gpio_oe_in,
  input  wire logic [3:0]           pin_i_in,
  input  wire logic                 tdo_in,
  output logic [3:0]                pin_o_out,
  output logic [3:0]                pin_oe_out,
  output logic [3:0]                gpio_i_out,
  output cbi_pkg::cbi_tap_t         tap_state_out,
  output logic                      tap_tdi_out,
  // fast pulse-width outputs
  input  wire logic [FPW_N-1:0]     fpw_in,
  output logic [FPW_N-1:0]          fast_pulse_width_pins_out
);

  // ---------------------------------------------------------------
  // boot walk: firmware, config, log regions; last word holds sum
  // ---------------------------------------------------------------
  cbi_pkg::cbi_boot_t state_q;
  logic [1:0]  region_q;
  logic [15:0] ptr_q;
  logic [31:0] sum_q;
  logic [6:0]  addr_q;
  logic        fw_bad_q, cfg_bad_q, log_er_q, blank_q, jtag_q, log_en_q, done_q;
  logic        rd_host_q;
  logic [31:0] wdt_q;

  function automatic logic [15:0] reg_last(input logic [1:0] r);
    if (r == 2'd0) return 16'(FW_BASE + FW_LEN - 1);
    else if (r == 2'd1) return 16'(CFG_BASE + CFG_LEN - 1);
    else return 16'(LOG_BASE + LOG_LEN - 1);
  endfunction : reg_last

  wire [31:0] rd_word  = cbi_pkg::ecc_decode(fl_rd_data_in);
  wire        at_last  = (ptr_q == reg_last(region_q));
  wire        sum_bad  = (rd_word != sum_q);
  wire        got_word = fl_rd_valid_in && (state_q == cbi_pkg::S_WAIT);
  wire        chk_done = got_word && at_last;
  wire        cfg_fail = chk_done && (region_q == 2'd1) && sum_bad;
  wire        serving  = (state_q == cbi_pkg::S_RUN) || (state_q == cbi_pkg::S_HALT);
  wire        wr_ok    = serving && wp_disable_in;
  wire        erasing  = (state_q == cbi_pkg::S_ERASE);
  wire        in_run   = (state_q == cbi_pkg::S_RUN);
  wire        host_wr  = wr_ok && host_wr_in.valid && !host_erase_in;
  wire        blank_nx = blank_q && (fl_rd_data_in == cbi_pkg::ERASED_CW);
  wire        jtag_nx  = blank_nx || (addr_q == cbi_pkg::JTAG_BUS_ADDR);

  // boot state machine; host reads are only taken once boot has ended
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= cbi_pkg::S_START;
      region_q <= 2'd0;
      ptr_q <= 16'h0000;
      sum_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        cbi_pkg::S_START: begin
          ptr_q <= 16'(FW_BASE);
          state_q <= cbi_pkg::S_FETCH;
        end
        cbi_pkg::S_FETCH: state_q <= cbi_pkg::S_WAIT;
        cbi_pkg::S_WAIT: begin
          if (fl_rd_valid_in && !at_last) begin
            sum_q <= sum_q + rd_word;
            ptr_q <= ptr_q + 16'h0001;
            state_q <= cbi_pkg::S_FETCH;
          end else if (fl_rd_valid_in) begin
            sum_q <= 32'h0000_0000;
            region_q <= region_q + 2'd1;
            ptr_q <= (region_q == 2'd0) ? 16'(CFG_BASE) : 16'(LOG_BASE);
            case (region_q)
              2'd0: state_q <= sum_bad ? cbi_pkg::S_HALT : cbi_pkg::S_FETCH;
              2'd1: state_q <= cbi_pkg::S_FETCH;
              default: state_q <= sum_bad ? cbi_pkg::S_ERASE : cbi_pkg::S_RUN;
            endcase
          end
        end
        cbi_pkg::S_ERASE: state_q <= cbi_pkg::S_RUN;
        default: state_q <= state_q;
      endcase
    end
  end

  // check results; jtag stays off until the config walk has decided
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fw_bad_q <= 1'b0;
      cfg_bad_q <= 1'b0;
      log_er_q <= 1'b0;
      blank_q <= 1'b1;
      jtag_q <= 1'b0;
      done_q <= 1'b0;
      fw_run_out <= 1'b0;
      addr_q <= 7'h00;
    end else begin
      if (state_q == cbi_pkg::S_START) addr_q <= bus_addr_in;        // caught after release
      if (got_word && region_q == 2'd1) blank_q <= blank_nx;
      if (chk_done && region_q == 2'd0) fw_bad_q <= sum_bad;
      if (chk_done && region_q == 2'd1) cfg_bad_q <= sum_bad;
      if (chk_done && region_q == 2'd1) jtag_q <= jtag_nx;
      if (state_q == cbi_pkg::S_ERASE) log_er_q <= 1'b1;
      done_q <= serving;
      fw_run_out <= done_q && !fw_bad_q;
    end
  end

  // alert is sticky; a new failure beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) bus_alert_out <= 1'b0;
    else bus_alert_out <= cfg_fail || (bus_alert_out && !alert_clr_in);
  end

  // fault logging off after any image write until the next reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) log_en_q <= 1'b1;
    else if (host_wr) log_en_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // flash ports: reads corrected, writes encoded
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fl_rd_out <= '0;
      fl_wr_out <= '0;
      rd_host_q <= 1'b0;
      host_rd_valid_out <= 1'b0;
      host_rd_data_out <= 32'h0000_0000;
    end else begin
      fl_rd_out.valid <= (state_q == cbi_pkg::S_FETCH) || (serving && host_rd_in.valid);
      fl_rd_out.addr <= serving ? host_rd_in.addr : ptr_q;
      // held until the flash answers, whatever its latency
      rd_host_q <= (serving && host_rd_in.valid) || (rd_host_q && !fl_rd_valid_in);
      host_rd_valid_out <= rd_host_q && fl_rd_valid_in;
      if (rd_host_q && fl_rd_valid_in) host_rd_data_out <= rd_word;
      fl_wr_out.valid <= erasing || (wr_ok && (host_erase_in || host_wr_in.valid));
      fl_wr_out.addr <= erasing ? 16'(LOG_BASE) : host_wr_in.addr;
      if (erasing) fl_wr_out.op <= cbi_pkg::OP_ERASE_LOG;
      else if (host_erase_in) fl_wr_out.op <= cbi_pkg::OP_ERASE_ALL;
      else fl_wr_out.op <= cbi_pkg::OP_WRITE;
      fl_wr_out.cw <= cbi_pkg::ecc_encode(host_wr_in.data);
    end
  end

  // ---------------------------------------------------------------
  // parameter range check and watchdog
  // ---------------------------------------------------------------
  wire par_in_rng = cbi_pkg::param_in_range(param_in.index, param_in.value);
  wire wdt_end    = (wdt_q == 32'(WDT_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      param_ok_out <= 1'b0;
      param_err_out <= 1'b0;
      wdt_q <= 32'h0000_0000;
      wdt_rst_out <= 1'b0;
    end else begin
      param_ok_out <= param_in.valid && par_in_rng;
      param_err_out <= param_in.valid && !par_in_rng;
      wdt_q <= (!in_run || wdt_kick_in || wdt_end) ? 32'h0000_0000 : wdt_q + 32'h1;
      wdt_rst_out <= in_run && !wdt_kick_in && wdt_end;
    end
  end

  // ---------------------------------------------------------------
  // pins: two-flop input sync, tap tracker, gated outputs
  // ---------------------------------------------------------------
  logic [3:0] pin_s1_q, pin_s2_q;
  logic       tck_prev_q;
  cbi_pkg::cbi_tap_t tap_nx;
  wire        tck_rise = pin_s2_q[0] && !tck_prev_q;
  wire        tms      = pin_s2_q[1];
  wire        shifting = (tap_state_out == cbi_pkg::T_SH_DR) ||
                         (tap_state_out == cbi_pkg::T_SH_IR);

  // tap walk only; no scan cells stand behind it
  always_comb begin
    case (tap_state_out)
      cbi_pkg::T_RESET:  tap_nx = tms ? cbi_pkg::T_RESET  : cbi_pkg::T_IDLE;
      cbi_pkg::T_IDLE:   tap_nx = tms ? cbi_pkg::T_SEL_DR : cbi_pkg::T_IDLE;
      cbi_pkg::T_SEL_DR: tap_nx = tms ? cbi_pkg::T_SEL_IR : cbi_pkg::T_CAP_DR;
      cbi_pkg::T_CAP_DR: tap_nx = tms ? cbi_pkg::T_EX1_DR : cbi_pkg::T_SH_DR;
      cbi_pkg::T_SH_DR:  tap_nx = tms ? cbi_pkg::T_EX1_DR : cbi_pkg::T_SH_DR;
      cbi_pkg::T_EX1_DR: tap_nx = tms ? cbi_pkg::T_UP_DR  : cbi_pkg::T_PA_DR;
      cbi_pkg::T_PA_DR:  tap_nx = tms ? cbi_pkg::T_EX2_DR : cbi_pkg::T_PA_DR;
      cbi_pkg::T_EX2_DR: tap_nx = tms ? cbi_pkg::T_UP_DR  : cbi_pkg::T_SH_DR;
      cbi_pkg::T_SEL_IR: tap_nx = tms ? cbi_pkg::T_RESET  : cbi_pkg::T_CAP_IR;
      cbi_pkg::T_CAP_IR: tap_nx = tms ? cbi_pkg::T_EX1_IR : cbi_pkg::T_SH_IR;
      cbi_pkg::T_SH_IR:  tap_nx = tms ? cbi_pkg::T_EX1_IR : cbi_pkg::T_SH_IR;
      cbi_pkg::T_EX1_IR: tap_nx = tms ? cbi_pkg::T_UP_IR  : cbi_pkg::T_PA_IR;
      cbi_pkg::T_PA_IR:  tap_nx = tms ? cbi_pkg::T_EX2_IR : cbi_pkg::T_PA_IR;
      cbi_pkg::T_EX2_IR: tap_nx = tms ? cbi_pkg::T_UP_IR  : cbi_pkg::T_SH_IR;
      default:           tap_nx = tms ? cbi_pkg::T_SEL_DR : cbi_pkg::T_IDLE;
    endcase
  end

  // outputs stay released until boot ends, not only during reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      tck_prev_q <= 1'b0;
      tap_state_out <= cbi_pkg::T_RESET;
      tap_tdi_out <= 1'b0;
      gpio_i_out <= 4'h0;
      pin_o_out <= 4'h0;
      pin_oe_out <= 4'h0;
      fast_pulse_width_pins_out <= '0;
    end else begin
      pin_s1_q <= pin_i_in;
      pin_s2_q <= pin_s1_q;
      tck_prev_q <= pin_s2_q[0];
      if (jtag_q && tck_rise) tap_state_out <= tap_nx;
      if (jtag_q && tck_rise) tap_tdi_out <= pin_s2_q[2];
      gpio_i_out <= jtag_q ? 4'h0 : pin_s2_q;
      pin_o_out <= jtag_q ? {tdo_in, 3'b000} : gpio_o_in;
      pin_oe_out <= !done_q ? 4'h0 : jtag_q ? {shifting, 3'b000} : gpio_oe_in;
      fast_pulse_width_pins_out <= done_q && !fw_bad_q ? fpw_in : '0;
    end
  end

  // status and default-config outputs
  assign use_default_cfg_out = cfg_bad_q;
  assign status_out = '{boot_done: done_q, fw_bad: fw_bad_q, cfg_bad: cfg_bad_q,
                        log_erased: log_er_q, flash_blank: blank_q, jtag_en: jtag_q,
                        log_en: log_en_q};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_fw_halt;
    fw_bad_q && done_q |-> !fw_run_out && state_q == cbi_pkg::S_HALT;
  endproperty
  a_fw_halt: assert property (p_fw_halt) else $error("bad firmware yet running");
  property p_cfg_alert;
    cfg_fail |=> cfg_bad_q && bus_alert_out && use_default_cfg_out;
  endproperty
  a_cfg_alert: assert property (p_cfg_alert) else $error("config failure not flagged");
  property p_log_erase;
    chk_done && region_q == 2'd2 && sum_bad |=> ##1 fl_wr_out.valid
      && fl_wr_out.op == cbi_pkg::OP_ERASE_LOG && log_er_q;
  endproperty
  a_log_erase: assert property (p_log_erase) else $error("corrupt log not erased");
  property p_wdt;
    $rose(wdt_rst_out) |-> $past(wdt_q) == 32'(WDT_CYCLES - 1) && $past(in_run);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset at wrong count");
  property p_rst_pins;
    !done_q |-> pin_oe_out == 4'h0 && fast_pulse_width_pins_out == '0;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins driven before boot end");
  property p_param;
    param_in.valid |=> param_ok_out == $past(par_in_rng) && param_err_out != param_ok_out;
  endproperty
  a_param: assert property (p_param) else $error("parameter range verdict wrong");
  property p_ecc_wr;
    host_wr |=> cbi_pkg::ecc_decode(fl_wr_out.cw) == $past(host_wr_in.data);
  endproperty
  a_ecc_wr: assert property (p_ecc_wr) else $error("stored word does not decode");
  property p_ecc_rd;
    rd_host_q && fl_rd_valid_in |=> host_rd_valid_out
      && host_rd_data_out == cbi_pkg::ecc_decode($past(fl_rd_data_in));
  endproperty
  a_ecc_rd: assert property (p_ecc_rd) else $error("read data not corrected");
  property p_jtag;
    $rose(jtag_q) |-> $past(blank_nx) || addr_q == cbi_pkg::JTAG_BUS_ADDR;
  endproperty
  a_jtag: assert property (p_jtag) else $error("jtag enabled without cause");
  property p_log_off;
    host_wr |=> !log_en_q [*3];
  endproperty
  a_log_off: assert property (p_log_off) else $error("logging still on after write");

  c_run: cover property (state_q == cbi_pkg::S_FETCH ##[1:200] in_run);
  c_halt: cover property ($rose(fw_bad_q));
  c_jtag: cover property ($rose(jtag_q) ##[1:50] tck_rise);
  c_update: cover property (host_erase_in && wr_ok ##[1:20] host_wr);

endmodule : cbi_boot_ctrl

// >>> cbi_flash_model.sv
// flash array model that answers the boot controller's reads and writes
`timescale 1ns/1ps

module cbi_flash_model #(
  parameter int LOG_LEN = 8
) (
  // clock and answer latency
  input  wire logic                 clk_in,
  input  wire logic [3:0]           lat_in,
  // request side
  input  wire cbi_pkg::cbi_rd_req_t rd_in,
  input  wire cbi_pkg::cbi_fl_wr_t  wr_in,
  // answer side
  output logic [37:0]               rd_data_out,
  output logic                      rd_valid_out
);
  logic [37:0] mem [int];
  logic        pend_q = 1'b0;
  int          cnt_q  = 0;
  int          a_q    = 0;

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  initial rd_valid_out = 1'b0;
  initial rd_data_out = '0;
  // one request at a time; data is inverted once released so it never holds
  always @(posedge clk_in) begin
    rd_valid_out <= 1'b0;
    if (rd_valid_out) rd_data_out <= ~rd_data_out;
    if (rd_in.valid === 1'b1) begin
      pend_q = 1'b1;
      cnt_q  = lat_in;
      a_q    = rd_in.addr;
    end else if (pend_q && cnt_q > 0) cnt_q--;
    if (pend_q && cnt_q == 0) begin
      rd_valid_out <= 1'b1;
      rd_data_out  <= mem.exists(a_q) ? mem[a_q] : cbi_pkg::ERASED_CW;
      pend_q = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write and erase side
  // ---------------------------------------------------------------
  // erased words vanish from the array and read back all ones
  always @(posedge clk_in) begin
    if (wr_in.valid === 1'b1 && wr_in.op == cbi_pkg::OP_WRITE) mem[wr_in.addr] = wr_in.cw;
    if (wr_in.valid === 1'b1 && wr_in.op == cbi_pkg::OP_ERASE_ALL) mem.delete();
    if (wr_in.valid === 1'b1 && wr_in.op == cbi_pkg::OP_ERASE_LOG)
      for (int i = 0; i < LOG_LEN; i++) mem.delete(int'(wr_in.addr) + i);
  end
endmodule : cbi_flash_model

// >>> cbi_pkg.sv
// package: constants, carriers and ecc helpers for the config boot integrity block
package cbi_pkg;

  // ---------------------------------------------------------------
  // widths and codes
  // ---------------------------------------------------------------
  localparam int          DATA_W        = 32;
  localparam int          CHK_W         = 6;
  localparam int          CW_W          = DATA_W + CHK_W;
  localparam int          FA_W          = 16;
  localparam logic [6:0]  JTAG_BUS_ADDR = 7'h7e;
  localparam logic [37:0] ERASED_CW     = 38'h3f_ffff_ffff;

  // ---------------------------------------------------------------
  // timing: watchdog period in microseconds at 125 MHz
  // ---------------------------------------------------------------
  localparam int CLK_MHZ    = 125;
  localparam int WDT_US     = 1000;
  localparam int WDT_CYCLES = WDT_US * CLK_MHZ;

  // parameter limits, index 0..3 (plain defaults)
  localparam logic [31:0] PARAM_MIN [4] = '{32'h0000_0000, 32'h0000_0010,
                                             32'h0000_0000, 32'h0000_0001};
  localparam logic [31:0] PARAM_MAX [4] = '{32'h0000_0fff, 32'h0000_ffff,
                                             32'h0000_00ff, 32'h0000_0064};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {S_START, S_FETCH, S_WAIT, S_ERASE, S_RUN, S_HALT} cbi_boot_t;
  typedef enum logic [3:0] {T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR,
                            T_PA_DR, T_EX2_DR, T_UP_DR, T_SEL_IR, T_CAP_IR, T_SH_IR,
                            T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR} cbi_tap_t;
  typedef enum logic [1:0] {OP_WRITE, OP_ERASE_ALL, OP_ERASE_LOG} cbi_op_t;

  typedef struct packed {logic valid; logic [FA_W-1:0] addr;} cbi_rd_req_t;
  typedef struct packed {logic valid; cbi_op_t op; logic [FA_W-1:0] addr;
                         logic [CW_W-1:0] cw;} cbi_fl_wr_t;
  typedef struct packed {logic valid; logic [FA_W-1:0] addr;
                         logic [DATA_W-1:0] data;} cbi_host_wr_t;
  typedef struct packed {logic valid; logic [1:0] index; logic [31:0] value;} cbi_param_t;
  typedef struct packed {logic boot_done; logic fw_bad; logic cfg_bad; logic log_erased;
                         logic flash_blank; logic jtag_en; logic log_en;} cbi_status_t;

  // ---------------------------------------------------------------
  // hamming code: check bits at power-of-two positions 1..32
  // ---------------------------------------------------------------
  function automatic logic [37:0] ecc_encode(input logic [31:0] d);
    logic [38:1] c;
    int          k;
    c = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 6; b++) begin
      for (int p = 1; p <= 38; p++) begin
        if (p[b] && (p != (1 << b))) c[1 << b] ^= c[p];
      end
    end
    return c;
  endfunction : ecc_encode

  // single-bit errors are corrected; double errors pass uncaught
  function automatic logic [31:0] ecc_decode(input logic [37:0] cw);
    logic [38:1] c;
    logic [5:0]  s;
    logic [31:0] d;
    int          k;
    c = cw;
    s = '0;
    d = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if (c[p]) s ^= p[5:0];
    end
    if (s != 6'h00 && s <= 6'h26) c[s] = ~c[s];
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction : ecc_decode

  function automatic logic param_in_range(input logic [1:0] i, input logic [31:0] v);
    return (v >= PARAM_MIN[i]) && (v <= PARAM_MAX[i]);
  endfunction : param_in_range

endpackage : cbi_pkg

// >>> tb.sv
// self-checking bench for the boot integrity controller
`timescale 1ns/1ps

module tb;
  localparam int FB = 16'h0000;
  localparam int CB = 16'h0100;
  localparam int LB = 16'h0200;
  logic clk_in = 0, sys_rst_in = 1, wdt_kick_in = 1, alert_clr_in = 0;
  logic wp_disable_in = 0, host_erase_in = 0, tdo_in = 0, fl_rd_valid_in;
  logic wdt_rst_out, bus_alert_out, fw_run_out, use_default_cfg_out;
  logic host_rd_valid_out, param_ok_out, param_err_out, tap_tdi_out;
  logic [6:0]  bus_addr_in = 7'h10;
  logic [3:0]  lat = 0, gpio_o_in = 0, gpio_oe_in = 0, pin_i_in = 0;
  logic [3:0]  pin_o_out, pin_oe_out, gpio_i_out;
  logic [7:0]  fpw_in = 0, fast_pulse_width_pins_out;
  logic [37:0] fl_rd_data_in;
  logic [31:0] host_rd_data_out, flip_d;
  cbi_pkg::cbi_host_wr_t host_wr_in = '0;
  cbi_pkg::cbi_rd_req_t  host_rd_in = '0, fl_rd_out;
  cbi_pkg::cbi_param_t   param_in = '0;
  cbi_pkg::cbi_status_t  status_out;
  cbi_pkg::cbi_fl_wr_t   fl_wr_out, wq[$];
  cbi_pkg::cbi_tap_t     tap_state_out;
  logic [37:0]           eq[$];
  int mismatches = 0, checks_done = 0, wdt_n = 0, n;

  cbi_boot_ctrl #(.WDT_CYCLES(16)) dut (.*);
  cbi_flash_model #(.LOG_LEN(8)) flash (.clk_in(clk_in), .lat_in(lat), .rd_in(fl_rd_out),
    .wr_in(fl_wr_out), .rd_data_out(fl_rd_data_in), .rd_valid_out(fl_rd_valid_in));

  // ---------------------------------------------------------------
  // clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial forever #4 clk_in = ~clk_in;
  // flash write pulses and watchdog pulses last one cycle, so log them at every edge
  always @(posedge clk_in) begin
    if (fl_wr_out.valid === 1'b1) wq.push_back(fl_wr_out);
    if (wdt_rst_out === 1'b1) wdt_n++;
  end
  // a whole run is well under 20000 cycles
  initial begin
    #(8 * 60000);
    mismatches++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // reference codeword: parity at positions 1,2,4..32, data lsb first elsewhere
  function automatic logic [37:0] enc(input logic [31:0] d);
    logic [37:0] c;
    int          k;
    c = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) if ((p & (p - 1)) != 0) begin
      c[p-1] = d[k];
      k++;
    end
    for (int b = 0; b < 6; b++)
      for (int p = 1; p <= 38; p++) if (p[b] && p != (1 << b)) c[(1 << b) - 1] ^= c[p-1];
    return c;
  endfunction : enc

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [37:0] e, input logic [37:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // three regions, last word holds the sum of the others; bad adds one
  task automatic img(input bit fb, cb, lb, bl, host);
    int          base, len;
    logic [31:0] s, d;
    logic [37:0] c;
    for (int r = 0; r < 3; r++) begin
      base = r == 0 ? FB : r == 1 ? CB : LB;
      len  = r == 2 ? 8 : 16;
      s    = '0;
      for (int i = 0; i < len; i++) begin
        d = (i == len - 1) ? s + 32'((r == 0 && fb) || (r == 1 && cb) || (r == 2 && lb))
                           : $urandom;
        s += d;
        c = enc(d);
        if (host) begin
          host_wr_in <= '{1'b1, 16'(base + i), d};
          eq.push_back(c);
          @(negedge clk_in);
        end else if (bl && r == 1) flash.mem[base + i] = cbi_pkg::ERASED_CW;
        else if (r == 1 && i == 3) begin
          flash.mem[base + i] = c ^ 38'h00_0000_0020;  // single stored bit flipped
          flip_d = d;
        end else flash.mem[base + i] = c;
      end
    end
    host_wr_in <= '0;
  endtask : img

  task automatic boot(input bit fb, cb, lb, bl, input logic [6:0] ad, input bit fresh);
    if (fresh) flash.mem.delete();
    if (fresh) img(fb, cb, lb, bl, 0);
    bus_addr_in <= ad;
    lat         <= 4'($urandom % 6);
    fpw_in      <= '1;
    gpio_oe_in  <= '1;
    sys_rst_in  <= 1'b1;
    repeat (10) @(negedge clk_in);
    chk_word("fpw_in_reset", '0, fast_pulse_width_pins_out);
    chk_word("oe_in_reset", '0, pin_oe_out);
    wq.delete();
    sys_rst_in <= 1'b0;
    n = 0;
    while (status_out.boot_done !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (4) @(negedge clk_in);
    chk_bit("boot_done", 1, status_out.boot_done);
    chk_bit("fw_run", !fb, fw_run_out);
    chk_bit("fw_bad", fb, status_out.fw_bad);
    chk_bit("log_en", 1, status_out.log_en);
    if (!fb) begin
      chk_bit("use_default", cb | bl, use_default_cfg_out);
      chk_bit("alert", cb | bl, bus_alert_out);
      chk_bit("cfg_bad", cb | bl, status_out.cfg_bad);
      chk_bit("jtag_en", bl || ad == 7'h7e, status_out.jtag_en);
      chk_bit("log_erased", lb, status_out.log_erased);
      chk_bit("log_wipe", lb, wq.size() == 1 && wq[0].op == cbi_pkg::OP_ERASE_LOG);
    end else chk_word("fpw_halted", '0, fast_pulse_width_pins_out);
  endtask : boot

  // shared pins follow the sequencer only while the test port is off
  task automatic pins(input bit jt);
    logic [3:0] o, e, i;
    logic [7:0] f;
    for (int k = 0; k < 6; k++) begin
      o = $urandom;
      e = $urandom;
      i = 4'($urandom) | {2'b00, jt, 1'b0};  // tms high keeps the tap out of shift
      f = $urandom;
      gpio_o_in  <= o;
      gpio_oe_in <= e;
      pin_i_in   <= i;
      fpw_in     <= f;
      repeat (5) @(negedge clk_in);
      chk_word("pin_oe", jt ? 4'h0 : e, pin_oe_out);
      chk_word("gpio_i", jt ? 4'h0 : i, gpio_i_out);
      if (!jt) chk_word("pin_o", o, pin_o_out);
      chk_word("fpw", f, fast_pulse_width_pins_out);
    end
  endtask : pins

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0]  x;
    void'($urandom(32'hb7c6));
    boot(0, 0, 0, 0, 7'h10, 1);
    pins(0);
    for (int k = 0; k < 16; k++) begin
      x = $urandom;
      v = $urandom_range(0, cbi_pkg::PARAM_MAX[x] + 2);
      param_in <= '{1'b1, x, v};
      @(negedge clk_in);
      param_in <= '0;
      n = int'(v >= cbi_pkg::PARAM_MIN[x] && v <= cbi_pkg::PARAM_MAX[x]);
      chk_bit("param_ok", n[0], param_ok_out);
      chk_bit("param_err", !n[0], param_err_out);
      @(negedge clk_in);
    end
    wdt_n = 0;
    repeat (30) @(negedge clk_in);
    chk_word("wdt_kicked", 0, 38'(wdt_n));
    wdt_kick_in <= 0;
    n = 0;
    while (wdt_rst_out !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    wdt_kick_in <= 1;
    chk_bit("wdt_span", 1, n >= 15 && n <= 18);
    host_rd_in <= '{1'b1, 16'(CB + 3)};
    @(negedge clk_in);
    host_rd_in <= '0;
    n = 0;
    while (host_rd_valid_out !== 1'b1 && n < 30) begin
      @(negedge clk_in);
      n++;
    end
    chk_word("host_rd", 38'(flip_d), 38'(host_rd_data_out));
    wq.delete();
    host_wr_in <= '{1'b1, 16'(CB), 32'h1};
    @(negedge clk_in);
    host_wr_in <= '0;
    repeat (3) @(negedge clk_in);
    chk_word("wr_protected", 0, 38'(wq.size()));
    // update order: unprotect, erase, write image, reset
    wp_disable_in <= 1;
    eq.delete();
    host_erase_in <= 1;
    @(negedge clk_in);
    host_erase_in <= 0;
    img(0, 0, 0, 0, 1);
    repeat (3) @(negedge clk_in);
    chk_word("wr_count", 41, 38'(wq.size()));
    chk_bit("erase_all", 1, wq[0].op == cbi_pkg::OP_ERASE_ALL);
    for (int k = 0; k < eq.size() && k + 1 < wq.size(); k++)
      chk_word("wr_cw", eq[k], wq[k + 1].cw);
    chk_bit("log_off", 0, status_out.log_en);
    chk_bit("old_cfg", 0, use_default_cfg_out);
    chk_bit("old_run", 1, fw_run_out);
    wp_disable_in <= 0;
    boot(0, 0, 0, 0, 7'h10, 0);
    boot(0, 1, 0, 0, 7'h22, 1);
    alert_clr_in <= 1;
    @(negedge clk_in);
    alert_clr_in <= 0;
    @(negedge clk_in);
    chk_bit("alert_cleared", 0, bus_alert_out);
    chk_bit("still_default", 1, use_default_cfg_out);
    boot(1, 0, 0, 0, 7'h10, 1);
    boot(0, 0, 1, 0, 7'h10, 1);
    boot(0, 0, 0, 1, 7'h10, 1);
    pins(1);
    boot(0, 0, 0, 0, 7'h7e, 1);
    pins(1);
    give_verdict();
  end
endmodule : tb
